/* File: src/awc_checker.sv */
// access window and memory map checker for fetch and load/store paths
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

module awc_checker
    import awc_pkg::*;
#(
    parameter awc_pkg::awc_win_bits_t  FETCH_WINDOW_ON        = '0,
    parameter awc_pkg::awc_win_words_t FETCH_WINDOW_BASE      = '0,
    parameter awc_pkg::awc_win_words_t FETCH_WINDOW_SIZE_MASK = '1,
    parameter awc_pkg::awc_win_bits_t  LDST_WINDOW_ON         = '0,
    parameter awc_pkg::awc_win_words_t LDST_WINDOW_BASE       = '0,
    parameter awc_pkg::awc_win_words_t LDST_WINDOW_SIZE_MASK  = '1,
    parameter bit          INSTR_LOCAL_MEM_PRESENT = 1'b1,
    parameter int          INSTR_LOCAL_MEM_REGION  = 14,
    parameter logic [27:0] INSTR_LOCAL_MEM_OFFSET  = 28'h000_0000,
    parameter int          INSTR_LOCAL_MEM_KBYTES  = 512,
    parameter int          DATA_LOCAL_MEM_REGION   = 15,
    parameter logic [27:0] DATA_LOCAL_MEM_OFFSET   = 28'h004_0000,
    parameter int          DATA_LOCAL_MEM_KBYTES   = 64,
    parameter bit          ICACHE_PRESENT          = 1'b1,
    parameter int          ICACHE_KBYTES           = 16,
    parameter bit          ICACHE_PROTECT_SELECT   = 1'b0,
    parameter int          IRQ_CTRL_BLOCK_REGION   = 15,
    parameter logic [27:0] IRQ_CTRL_BLOCK_OFFSET   = 28'h00C_0000,
    parameter int          IRQ_CTRL_BLOCK_KBYTES   = 32
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    // fetch request
    input  wire logic              fetch_valid_in,
    input  wire logic [31:0]       fetch_addr_in,
    // load/store request
    input  wire logic              ldst_valid_in,
    input  wire logic [31:0]       ldst_addr_in,
    input  wire awc_pkg::awc_size_t ldst_size_in,
    input  wire logic              ldst_idempotent_in,
    // fetch verdict
    output logic                   fetch_done_out,
    output logic                   fetch_access_fault_out,
    output logic                   fetch_misalign_out,
    output logic                   fetch_in_local_mem_out,
    output logic [31:0]            fetch_fault_addr_out,
    // load/store verdict
    output logic                   ldst_done_out,
    output logic                   ldst_access_fault_out,
    output logic                   ldst_misalign_out,
    output logic                   ldst_in_data_mem_out,
    output logic                   ldst_in_irq_ctrl_out,
    output logic [31:0]            ldst_fault_addr_out,
    // configuration view
    output logic                   icache_ecc_out,
    // interrupt
    output logic                   irq_out,
    // status, mask and fault address registers
    input  wire logic [3:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [31:0]            reg_rdata_out
);
    import awc_pkg::*;

    localparam logic [3:0] AWC_REG_STATUS = 4'h0;
    localparam logic [3:0] AWC_REG_MASK   = 4'h4;
    localparam logic [3:0] AWC_REG_FADDR  = 4'h8;

    // block placements in the 32-bit space
    localparam logic [31:0] IMEM_SPAN =
        awc_align_bytes(INSTR_LOCAL_MEM_KBYTES);
    localparam logic [31:0] DMEM_SPAN = awc_align_bytes(DATA_LOCAL_MEM_KBYTES);
    localparam logic [31:0] IRQB_SPAN = awc_align_bytes(IRQ_CTRL_BLOCK_KBYTES);
    localparam logic [31:0] IMEM_BASE = {4'(INSTR_LOCAL_MEM_REGION),
                                         INSTR_LOCAL_MEM_OFFSET};
    localparam logic [31:0] DMEM_BASE = {4'(DATA_LOCAL_MEM_REGION),
                                         DATA_LOCAL_MEM_OFFSET};
    localparam logic [31:0] IRQB_BASE = {4'(IRQ_CTRL_BLOCK_REGION),
                                         IRQ_CTRL_BLOCK_OFFSET};
    localparam logic [31:0] DMEM_LEN  = 32'(DATA_LOCAL_MEM_KBYTES) * AWC_KB;

    function automatic bit win_ok(input logic [31:0] b, input logic [31:0] m);
        win_ok = ((b & AWC_WIN_LOW_MASK) == '0)
              && ((m & AWC_WIN_LOW_MASK) == AWC_WIN_LOW_MASK)
              && (((m + 32'h1) & m) == '0)
              && ((b & m) == '0);
    endfunction

    function automatic bit blk_ok(input logic [31:0] base,
                                  input logic [31:0] span);
        logic [32:0] off_end;
        off_end = {5'h0, base[27:0]} + {1'b0, span};
        blk_ok = ((base & (span - 32'h1)) == '0)
              && (off_end <= 33'h1_000_0000);
    endfunction

    function automatic bit disjoint(input logic [31:0] a,
                                    input logic [31:0] sa,
                                    input logic [31:0] b,
                                    input logic [31:0] sb);
        disjoint = ({1'b0, a} + {1'b0, sa} <= {1'b0, b})
                || ({1'b0, b} + {1'b0, sb} <= {1'b0, a});
    endfunction

    function automatic bit isz_ok(input int k);
        isz_ok = (k == 4 || k == 8 || k == 16 || k == 32 || k == 64 ||
                  k == 128 || k == 256 || k == 512);
    endfunction

    // elaboration-time refusal of illegal builds
    generate
        for (genvar w = 0; w < AWC_NUM_WIN; w++) begin : g_cfg
            if (!win_ok(FETCH_WINDOW_BASE[w], FETCH_WINDOW_SIZE_MASK[w]))
                $error("fetch window base/mask illegal");
            if (!win_ok(LDST_WINDOW_BASE[w], LDST_WINDOW_SIZE_MASK[w]))
                $error("load/store window base/mask illegal");
        end
    endgenerate
    generate
        if (INSTR_LOCAL_MEM_PRESENT && !isz_ok(INSTR_LOCAL_MEM_KBYTES))
            $error("fetch memory size illegal");
        if (!(isz_ok(DATA_LOCAL_MEM_KBYTES) || DATA_LOCAL_MEM_KBYTES == 48))
            $error("data memory size illegal");
        if (IRQ_CTRL_BLOCK_KBYTES != 32 && IRQ_CTRL_BLOCK_KBYTES != 64 &&
            IRQ_CTRL_BLOCK_KBYTES != 128 && IRQ_CTRL_BLOCK_KBYTES != 256)
            $error("interrupt block size illegal");
        if (ICACHE_PRESENT && ICACHE_KBYTES != 16 && ICACHE_KBYTES != 32 &&
            ICACHE_KBYTES != 64 && ICACHE_KBYTES != 128 &&
            ICACHE_KBYTES != 256)
            $error("cache size illegal");
        if (INSTR_LOCAL_MEM_REGION < 0 || INSTR_LOCAL_MEM_REGION > 15 ||
            DATA_LOCAL_MEM_REGION < 0 || DATA_LOCAL_MEM_REGION > 15 ||
            IRQ_CTRL_BLOCK_REGION < 0 || IRQ_CTRL_BLOCK_REGION > 15)
            $error("region index illegal");
        if (!blk_ok(DMEM_BASE, DMEM_SPAN) || !blk_ok(IRQB_BASE, IRQB_SPAN))
            $error("block placement illegal");
        if (INSTR_LOCAL_MEM_PRESENT && !blk_ok(IMEM_BASE, IMEM_SPAN))
            $error("fetch memory placement illegal");
        if (!disjoint(DMEM_BASE, DMEM_SPAN, IRQB_BASE, IRQB_SPAN))
            $error("blocks overlap");
        if (INSTR_LOCAL_MEM_PRESENT &&
            (!disjoint(IMEM_BASE, IMEM_SPAN, DMEM_BASE, DMEM_SPAN) ||
             !disjoint(IMEM_BASE, IMEM_SPAN, IRQB_BASE, IRQB_SPAN)))
            $error("fetch memory overlaps");
    endgenerate

    // window matching, one slice per window
    awc_win_bits_t f_hit;
    awc_win_bits_t l_hit;
    generate
        for (genvar w = 0; w < AWC_NUM_WIN; w++) begin : g_win
            assign f_hit[w] = FETCH_WINDOW_ON[w] &&
                ((fetch_addr_in | FETCH_WINDOW_SIZE_MASK[w]) ==
                 (FETCH_WINDOW_BASE[w] | FETCH_WINDOW_SIZE_MASK[w]));
            assign l_hit[w] = LDST_WINDOW_ON[w] &&
                ((ldst_addr_in | LDST_WINDOW_SIZE_MASK[w]) ==
                 (LDST_WINDOW_BASE[w] | LDST_WINDOW_SIZE_MASK[w]));
        end
    endgenerate

    logic f_fault;
    logic l_fault;
    logic f_mis;
    logic l_mis;
    logic l_unal;
    assign f_fault = (FETCH_WINDOW_ON != '0) && (f_hit == '0);
    assign l_fault = (LDST_WINDOW_ON != '0) && (l_hit == '0);
    assign f_mis   = fetch_addr_in[0];

    always_comb begin
        unique case (ldst_size_in)
            AWC_SZ_BYTE: l_unal = 1'b0;
            AWC_SZ_HALF: l_unal = ldst_addr_in[0];
            AWC_SZ_WORD: l_unal = ldst_addr_in[1:0] != 2'h0;
            default:     l_unal = 1'b1;
        endcase
    end
    assign l_mis = l_unal && !ldst_idempotent_in;

    // fetch verdict registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fetch_done_out         <= AWC_RESET_BIT;
            fetch_access_fault_out <= AWC_RESET_BIT;
            fetch_misalign_out     <= AWC_RESET_BIT;
            fetch_in_local_mem_out <= AWC_RESET_BIT;
            fetch_fault_addr_out   <= AWC_RESET_ADDR;
        end else begin
            fetch_done_out         <= fetch_valid_in;
            fetch_access_fault_out <= fetch_valid_in && f_fault;
            fetch_misalign_out     <= fetch_valid_in && f_mis;
            fetch_in_local_mem_out <= fetch_valid_in &&
                INSTR_LOCAL_MEM_PRESENT &&
                ((fetch_addr_in & ~(IMEM_SPAN - 32'h1)) == IMEM_BASE);
            fetch_fault_addr_out   <= fetch_addr_in;
        end
    end

    // load/store verdict registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ldst_done_out         <= AWC_RESET_BIT;
            ldst_access_fault_out <= AWC_RESET_BIT;
            ldst_misalign_out     <= AWC_RESET_BIT;
            ldst_in_data_mem_out  <= AWC_RESET_BIT;
            ldst_in_irq_ctrl_out  <= AWC_RESET_BIT;
            ldst_fault_addr_out   <= AWC_RESET_ADDR;
        end else begin
            ldst_done_out         <= ldst_valid_in;
            ldst_access_fault_out <= ldst_valid_in && l_fault;
            ldst_misalign_out     <= ldst_valid_in && l_mis;
            // 48 KB memory holds only its real length of the 64 KB slot
            ldst_in_data_mem_out  <= ldst_valid_in &&
                (ldst_addr_in >= DMEM_BASE) &&
                ({1'b0, ldst_addr_in} < {1'b0, DMEM_BASE} + {1'b0, DMEM_LEN});
            ldst_in_irq_ctrl_out  <= ldst_valid_in &&
                ((ldst_addr_in & ~(IRQB_SPAN - 32'h1)) == IRQB_BASE);
            ldst_fault_addr_out   <= ldst_addr_in;
        end
    end

    assign icache_ecc_out = ICACHE_PRESENT && ICACHE_PROTECT_SELECT;

    // sticky status: [0] fetch fault [1] fetch misalign
    //                [2] ldst fault  [3] ldst misalign
    logic [3:0]  evt;
    logic [3:0]  status_q;
    logic [3:0]  mask_q;
    logic [31:0] faddr_q;
    assign evt = {ldst_valid_in && l_mis, ldst_valid_in && l_fault,
                  fetch_valid_in && f_mis, fetch_valid_in && f_fault};

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_q <= 4'h0;
        end else begin
            // new event wins over a write-one clear
            status_q <= (status_q & ~((reg_wr_in &&
                         reg_addr_in == AWC_REG_STATUS) ?
                         reg_wdata_in[3:0] : 4'h0)) | evt;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_q <= 4'h0;
        end else if (reg_wr_in && reg_addr_in == AWC_REG_MASK) begin
            mask_q <= reg_wdata_in[3:0];
        end
    end

    // latest faulting address, load/store first
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            faddr_q <= AWC_RESET_ADDR;
        end else if (evt[3:2] != 2'h0) begin
            faddr_q <= ldst_addr_in;
        end else if (evt[1:0] != 2'h0) begin
            faddr_q <= fetch_addr_in;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                AWC_REG_STATUS: reg_rdata_out <= {28'h0, status_q};
                AWC_REG_MASK:   reg_rdata_out <= {28'h0, mask_q};
                AWC_REG_FADDR:  reg_rdata_out <= faddr_q;
                default:        reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    assign irq_out = (status_q & mask_q) != 4'h0;

endmodule

/* File: src/awc_pkg.sv */
// package: constants and types for the access window and map checker
package awc_pkg;

    localparam int          AWC_NUM_WIN      = 8;
    localparam int          AWC_WIN_LSB      = 6;
    localparam logic [31:0] AWC_WIN_LOW_MASK = 32'h0000_003F;
    localparam int          AWC_REGION_BITS  = 28;
    localparam logic [31:0] AWC_KB           = 32'h0000_0400;
    localparam logic [31:0] AWC_RESET_ADDR   = 32'h0000_0000;
    localparam logic        AWC_RESET_BIT    = 1'b0;
    localparam logic [1:0]  AWC_RESET_SIZE   = 2'h0;

    // load/store access size encoding
    typedef enum logic [1:0] {
        AWC_SZ_BYTE = 2'b00,
        AWC_SZ_HALF = 2'b01,
        AWC_SZ_WORD = 2'b10
    } awc_size_t;

    typedef logic [AWC_NUM_WIN-1:0]       awc_win_bits_t;
    typedef logic [AWC_NUM_WIN-1:0][31:0] awc_win_words_t;

    // round a size in KB up to a power of two, in bytes
    function automatic logic [31:0] awc_align_bytes(input int kb);
        logic [31:0] b;
        b = 32'h0000_0400;
        while (b < 32'(kb) * AWC_KB) begin
            b = b << 1;
        end
        return b;
    endfunction

endpackage

/* File: verif/awc_checker_properties.sv */
// checker: port timing properties of the access window checker
`timescale 1ns/1ps
module awc_props
    import awc_pkg::*;
#(
    parameter bit ICACHE_PROTECT_SELECT = 1'b0
) (
    // clock, reset and requests
    input wire logic               clk_in,
    input wire logic               resetn_in,
    input wire logic               fetch_valid_in,
    input wire logic [31:0]        fetch_addr_in,
    input wire logic               ldst_valid_in,
    input wire logic [31:0]        ldst_addr_in,
    input wire awc_pkg::awc_size_t ldst_size_in,
    input wire logic               ldst_idempotent_in,
    // verdicts
    input wire logic               fetch_done_out,
    input wire logic               fetch_access_fault_out,
    input wire logic               fetch_misalign_out,
    input wire logic [31:0]        fetch_fault_addr_out,
    input wire logic               ldst_done_out,
    input wire logic               ldst_access_fault_out,
    input wire logic               ldst_misalign_out,
    input wire logic               icache_ecc_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_fetch_req;
        fetch_valid_in;
    endsequence
    sequence s_fetch_done;
        fetch_done_out && fetch_fault_addr_out == $past(fetch_addr_in);
    endsequence
    sequence s_ldst_unal;
        ldst_valid_in && !ldst_idempotent_in
            && ldst_size_in == AWC_SZ_WORD && ldst_addr_in[1:0] != 2'h0;
    endsequence
    property p_fetch_done;
        s_fetch_req |=> s_fetch_done;
    endproperty
    property p_fetch_odd;
        s_fetch_req ##0 fetch_addr_in[0] |=> fetch_misalign_out;
    endproperty
    property p_fetch_half;
        !fetch_addr_in[0] |=> !fetch_misalign_out;
    endproperty
    property p_fetch_idle;
        !fetch_valid_in |=> !(fetch_done_out || fetch_access_fault_out);
    endproperty
    property p_ldst_unal;
        s_ldst_unal |=> ldst_done_out && ldst_misalign_out;
    endproperty
    property p_ldst_idem;
        ldst_idempotent_in |=> !ldst_misalign_out;
    endproperty
    property p_ldst_idle;
        !ldst_valid_in |=> !(ldst_access_fault_out || ldst_misalign_out);
    endproperty
    property p_ecc;
        icache_ecc_out == ICACHE_PROTECT_SELECT;
    endproperty
    a_fetch_done: assert property (p_fetch_done)
        else $error("fetch verdict missing");
    a_fetch_odd: assert property (p_fetch_odd)
        else $error("odd fetch not flagged");
    a_fetch_half: assert property (p_fetch_half)
        else $error("halfword fetch flagged");
    a_fetch_idle: assert property (p_fetch_idle)
        else $error("fetch verdict without request");
    a_ldst_unal: assert property (p_ldst_unal)
        else $error("unaligned access not flagged");
    a_ldst_idem: assert property (p_ldst_idem)
        else $error("idempotent access flagged");
    a_ldst_idle: assert property (p_ldst_idle)
        else $error("ldst verdict without request");
    a_ecc: assert property (p_ecc)
        else $error("cache protection select wrong");
endmodule

bind awc_checker awc_props #(
    .ICACHE_PROTECT_SELECT(ICACHE_PROTECT_SELECT)
) u_props (.clk_in, .resetn_in, .fetch_valid_in, .fetch_addr_in,
    .ldst_valid_in, .ldst_addr_in, .ldst_size_in, .ldst_idempotent_in,
    .fetch_done_out, .fetch_access_fault_out, .fetch_misalign_out,
    .fetch_fault_addr_out, .ldst_done_out, .ldst_access_fault_out,
    .ldst_misalign_out, .icache_ecc_out);

/* File: verif/awc_checker_tb.sv */
// testbench: windows, memory map and event registers of awc_checker
`timescale 1ns/1ps
module awc_checker_tb;
    import awc_pkg::*;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        fv, lv, li, fd, ff, fm, fl, ld, lf, lm, ldm, lic, irq, ecc;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  ra = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] fa, la, ffa, lfa, rdat;
    awc_size_t   ls;
    int          num_errors = 0;
    int          n_tests = 0;
    initial forever #5 clk_in = ~clk_in;
    awc_core_model core (.clk_in, .fetch_valid_out(fv), .fetch_addr_out(fa),
        .ldst_valid_out(lv), .ldst_addr_out(la), .ldst_size_out(ls),
        .ldst_idem_out(li));
    awc_checker #(
        .FETCH_WINDOW_ON(8'h09),
        .FETCH_WINDOW_BASE('{3: 32'hE000_0000, 1: 32'h0000_4000,
                             0: 32'h0000_1000, default: 32'h0}),
        .FETCH_WINDOW_SIZE_MASK('{3: 32'h0007_FFFF, 0: 32'h0000_0FFF,
                                  default: 32'h0000_003F}),
        .LDST_WINDOW_ON(8'h80),
        .LDST_WINDOW_BASE('{7: 32'hF000_0000, default: 32'h0}),
        .LDST_WINDOW_SIZE_MASK('{7: 32'h00FF_FFFF, default: 32'h0000_003F})
    ) uut (.clk_in, .resetn_in, .fetch_valid_in(fv), .fetch_addr_in(fa),
        .ldst_valid_in(lv), .ldst_addr_in(la), .ldst_size_in(ls),
        .ldst_idempotent_in(li), .fetch_done_out(fd),
        .fetch_access_fault_out(ff), .fetch_misalign_out(fm),
        .fetch_in_local_mem_out(fl), .fetch_fault_addr_out(ffa),
        .ldst_done_out(ld), .ldst_access_fault_out(lf),
        .ldst_misalign_out(lm), .ldst_in_data_mem_out(ldm),
        .ldst_in_irq_ctrl_out(lic), .ldst_fault_addr_out(lfa),
        .icache_ecc_out(ecc), .irq_out(irq), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdat));
    task automatic check(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_in);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        check("reg_rdata", rdat, e);
    endtask
    task automatic fch(input logic [31:0] a, input logic f, m, h);
        core.fetch(a);
        #1;
        check("fetch_done", 32'(fd), 32'h1);
        check("fetch_fault", 32'(ff), 32'(f));
        check("fetch_misalign", 32'(fm), 32'(m));
        check("fetch_local", 32'(fl), 32'(h));
        check("fetch_addr", ffa, a);
    endtask
    task automatic lds(input logic [31:0] a, input awc_size_t s,
                       input logic i, f, m, dm, ic);
        core.ldst(a, s, i);
        #1;
        check("ldst_done", 32'(ld), 32'h1);
        check("ldst_fault", 32'(lf), 32'(f));
        check("ldst_misalign", 32'(lm), 32'(m));
        check("ldst_data_mem", 32'(ldm), 32'(dm));
        check("ldst_irq_block", 32'(lic), 32'(ic));
        check("ldst_addr", lfa, a);
    endtask
    task automatic t_fetch();
        fch(32'h0000_1000, 1'b0, 1'b0, 1'b0);
        fch(32'h0000_1FFE, 1'b0, 1'b0, 1'b0);
        fch(32'h0000_2000, 1'b1, 1'b0, 1'b0);
        fch(32'h0000_4000, 1'b1, 1'b0, 1'b0);
        fch(32'hE000_0000, 1'b0, 1'b0, 1'b1);
        fch(32'hE007_FFFD, 1'b0, 1'b1, 1'b1);
        fch(32'hE008_0000, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_ldst();
        lds(32'hF004_0000, AWC_SZ_WORD, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        lds(32'hF004_FFFE, AWC_SZ_HALF, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        lds(32'hF004_FFFE, AWC_SZ_WORD, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        lds(32'hF004_FFFE, AWC_SZ_WORD, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        lds(32'hF005_0000, AWC_SZ_BYTE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        lds(32'hF00C_7FFF, AWC_SZ_BYTE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        lds(32'hF00C_8000, AWC_SZ_BYTE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        lds(32'h0000_1000, AWC_SZ_BYTE, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_irq();
        reg_wr(4'h0, 32'h0000_000F);
        reg_rd(4'h0, 32'h0);
        reg_wr(4'h4, 32'h0000_0004);
        lds(32'h0000_0100, AWC_SZ_BYTE, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        check("irq_raised", 32'(irq), 32'h1);
        reg_rd(4'h0, 32'h0000_0004);
        reg_rd(4'h8, 32'h0000_0100);
        reg_wr(4'h0, 32'h0000_0004);
        check("irq_cleared", 32'(irq), 32'h0);
        fch(32'h0000_2000, 1'b1, 1'b0, 1'b0);
        check("irq_masked", 32'(irq), 32'h0);
        reg_rd(4'h0, 32'h0000_0001);
        reg_rd(4'h4, 32'h0000_0004);
        reg_wr(4'hC, 32'hFFFF_FFFF);
        reg_rd(4'hC, 32'h0);
    endtask
    task automatic t_reset();
        reg_wr(4'h4, 32'h0000_000F);
        check("irq_unmasked", 32'(irq), 32'h1);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check("irq_in_reset", 32'(irq), 32'h0);
        check("faddr_in_reset", ffa, 32'h0);
        @(posedge clk_in);
        resetn_in <= 1'b1;
        reg_rd(4'h4, 32'h0);
        reg_rd(4'h0, 32'h0);
        fch(32'h0000_1000, 1'b0, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        check("irq_reset", 32'(irq), 32'h0);
        check("icache_ecc", 32'(ecc), 32'h0);
        reg_rd(4'h0, 32'h0);
        reg_rd(4'h4, 32'h0);
        reg_rd(4'h8, 32'h0);
        t_fetch();
        t_ldst();
        t_irq();
        t_reset();
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        conclude();
    end
endmodule

/* File: verif/awc_core_model.sv */
// model: core pipeline issuing fetch and load/store requests
`timescale 1ns/1ps
module awc_core_model
    import awc_pkg::*;
(
    // clock
    input  wire logic         clk_in,
    // requests
    output logic              fetch_valid_out,
    output logic [31:0]       fetch_addr_out,
    output logic              ldst_valid_out,
    output logic [31:0]       ldst_addr_out,
    output awc_pkg::awc_size_t ldst_size_out,
    output logic              ldst_idem_out
);
    initial begin
        fetch_valid_out = 1'b0;
        fetch_addr_out = 32'h0;
        ldst_valid_out = 1'b0;
        ldst_addr_out = 32'h0;
        ldst_size_out = AWC_SZ_BYTE;
        ldst_idem_out = 1'b0;
    end
    // idle address lines show the inverse, never a stale target
    task automatic fetch(input logic [31:0] a);
        @(posedge clk_in);
        fetch_valid_out <= 1'b1;
        fetch_addr_out <= a;
        @(posedge clk_in);
        fetch_valid_out <= 1'b0;
        fetch_addr_out <= ~a;
    endtask
    task automatic ldst(input logic [31:0] a, input awc_size_t s,
                        input logic i);
        @(posedge clk_in);
        ldst_valid_out <= 1'b1;
        ldst_addr_out <= a;
        ldst_size_out <= s;
        ldst_idem_out <= i;
        @(posedge clk_in);
        ldst_valid_out <= 1'b0;
        ldst_addr_out <= ~a;
        ldst_idem_out <= ~i;
    endtask
endmodule
